// ---- rtl/hsd_pkg.sv ----
// Package of constants for the hub strap decode and boot sequencer
package hsd_pkg;

  localparam int unsigned NUM_PORTS = 7;

  // Six-level strap indices, weak pull-down first
  localparam logic [2:0] LVL_PD_200K = 3'h0;
  localparam logic [2:0] LVL_PU_200K = 3'h1;
  localparam logic [2:0] LVL_PD_10K  = 3'h2;
  localparam logic [2:0] LVL_PU_10K  = 3'h3;
  localparam logic [2:0] LVL_PD_10R  = 3'h4;
  localparam logic [2:0] LVL_PU_10R  = 3'h5;

  // Mode-select settings
  localparam logic [2:0] port_speed_indicator_no_slave_setting = LVL_PD_200K;
  localparam logic [2:0] port_speed_indicator_slave_setting    = LVL_PU_200K;
  localparam logic [2:0] reserved_setting_a         = LVL_PD_10K;
  localparam logic [2:0] reserved_setting_b         = LVL_PU_10K;
  localparam logic [2:0] charge_ind_setting         = LVL_PD_10R;
  localparam logic [2:0] reserved_setting_c         = LVL_PU_10R;

  // Port-count masks per strap level
  localparam logic [6:0] MASK_NONE = 7'h00;
  localparam logic [6:0] MASK_P1   = 7'h01;
  localparam logic [6:0] MASK_P12  = 7'h03;
  localparam logic [6:0] MASK_P123 = 7'h07;
  localparam logic [6:0] MASK_P1_4 = 7'h0f;
  localparam logic [6:0] MASK_ALL  = 7'h7f;

  // SPI ROM signature and addresses
  localparam logic [31:0] SPI_SIGNATURE  = 32'h32444655;
  localparam logic [15:0] SPI_SIG_ADDR   = 16'hfffa;
  localparam logic [15:0] SPI_EXEC_ADDR  = 16'h0000;
  localparam logic [7:0]  END_CFG_REG    = 8'hff;

  // Reference clock and default-load time
  localparam int unsigned CLK_MHZ        = 100;
  localparam int unsigned DFLT_LOAD_NS   = 100;
  localparam int unsigned DFLT_LOAD_CYC  = (DFLT_LOAD_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic [2:0] {
    HSD_STANDBY,
    HSD_SPI_INIT,
    HSD_CFG_READ,
    HSD_STRAP_READ,
    HSD_SOC_CFG,
    HSD_OTP_CFG
  } hsd_stage_e;

  // Six-level strap to port mask
  function automatic logic [6:0] hsd_level_mask(input logic [2:0] lvl);
    unique case (lvl)
      LVL_PD_200K: hsd_level_mask = MASK_NONE;
      LVL_PU_200K: hsd_level_mask = MASK_P1;
      LVL_PD_10K:  hsd_level_mask = MASK_P12;
      LVL_PU_10K:  hsd_level_mask = MASK_P123;
      LVL_PD_10R:  hsd_level_mask = MASK_P1_4;
      LVL_PU_10R:  hsd_level_mask = MASK_ALL;
      default:     hsd_level_mask = MASK_NONE;
    endcase
  endfunction : hsd_level_mask

endpackage : hsd_pkg

// ---- rtl/hsd_boot_sequencer.sv ----
// Strap decode, boot stage sequencer and indicator pin drive
//
// Overview of operation
// R1: Weak pull-up: slave enabled, speed indicators
// R2: Speed: float unconnected, low USB2, high Gen1
// R3: Strong pull-down: pins become charging indicators
// R4: Charging indicator floats when charging disabled
// R5: Charging: low after handshake, else high
// R6: Weak pull-down: slave disabled, speed indicators
// R7: Each disable strap: low enabled, high disabled
// R8: Port disabled only when both straps high
// R9: USB2 disable also disables Gen1 path
// R10: Fixed-port strap levels map to port sets
// R11: Charging strap levels map to port sets
// R12: Straps captured at reset release, held
// R13: GPIO direction, pull and level per pin
// R14: Standby while reset low, hub mode high
// R15: Standby clears everything, ports disabled, pins float; code resets port disables to 0 and leaves the synchroniser as is
// R16: After release: reset, SPI probe, then defaults
// R17: Signature found runs external, else internal
// R18: ROM size and speed set by far side
// R19: Not strapped for SPI skips probe
// R20: Defaults loaded, then straps overwrite them
// R21: Slave strap plus both pull-ups enters SoC stage
// R22: SoC stage waits without any timeout
// R23: Only end-of-configuration write leaves SoC stage
// R24: Completion leads to OTP merge stage
// R25: Reserved mode levels behave as weak pull-down
// R26: Boot stage exposed as encoded output
`timescale 1ns/1ps
`default_nettype none

module hsd_boot_sequencer
  import hsd_pkg::*;
#(
  parameter int unsigned NPORT     = NUM_PORTS,
  parameter int unsigned LOAD_CYC  = DFLT_LOAD_CYC,
  parameter int unsigned GPIO_W    = 8
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              reset_n,
  // Strap sense inputs, asynchronous
  input  wire logic [2:0]        mode_strap_level,
  input  wire logic [2:0]        fixed_port_count_strap,
  input  wire logic [2:0]        charging_port_count_strap,
  input  wire logic [NPORT-1:0]  plus_line_disable_strap,
  input  wire logic [NPORT-1:0]  minus_line_disable_strap,
  input  wire logic              spi_mode_strap,
  input  wire logic              mgmt_serial_data_pin,
  input  wire logic              mgmt_serial_clock_pin,
  // SPI probe and ROM load handshakes
  input  wire logic              spi_probe_done,
  input  wire logic              spi_sig_found,
  input  wire logic              dflt_load_done,
  // SoC configuration write from the slave logic
  input  wire logic              mgmt_wr_valid,
  input  wire logic [7:0]        mgmt_wr_addr,
  // Port status
  input  wire logic [NPORT-1:0]  port_connected,
  input  wire logic [NPORT-1:0]  port_gen1,
  input  wire logic [NPORT-1:0]  port_chg_handshake,
  // GPIO configuration
  input  wire logic [GPIO_W-1:0] gpio_out_mode,
  input  wire logic [GPIO_W-1:0] gpio_out_level,
  input  wire logic [GPIO_W-1:0] gpio_pull_up,
  // Stage and decoded configuration
  output logic [2:0]             boot_stage,
  output logic                   spi_probe_start,
  output logic                   exec_external,
  output logic [15:0]            exec_addr,
  output logic                   mgmt_slave_enable,
  output logic                   charge_ind_mode,
  output logic [NPORT-1:0]       port_usb2_disable,
  output logic [NPORT-1:0]       port_gen1_disable,
  output logic [NPORT-1:0]       fixed_port_mask,
  output logic [NPORT-1:0]       charge_enable_mask,
  output logic                   otp_merge_start,
  // Indicator pins, enable low while driven
  output logic [NPORT-1:0]       port_speed_indicator,
  output logic [NPORT-1:0]       port_speed_indicator_oe_n,
  output logic [NPORT-1:0]       charge_indicator,
  output logic [NPORT-1:0]       charge_indicator_oe_n,
  // GPIO pins
  output logic [GPIO_W-1:0]      gpio_o,
  output logic [GPIO_W-1:0]      gpio_oe_n,
  output logic [GPIO_W-1:0]      gpio_pu_en,
  output logic [GPIO_W-1:0]      gpio_pd_en
);

  localparam int unsigned SW = 3 * 3 + 2 * NPORT + 3;

  // Two-flop synchroniser on all strap and pin inputs
  // No reset: straps keep flowing in while reset is low, so they are settled at release
  logic [SW-1:0] sync1_q;
  logic [SW-1:0] sync2_q;
  always_ff @(posedge clk) begin
    sync1_q <= {mode_strap_level, fixed_port_count_strap, charging_port_count_strap,
                plus_line_disable_strap, minus_line_disable_strap, spi_mode_strap,
                mgmt_serial_data_pin, mgmt_serial_clock_pin};
    sync2_q <= sync1_q;
  end

  logic [2:0]       s_mode;
  logic [2:0]       s_fixed;
  logic [2:0]       s_chg;
  logic [NPORT-1:0] s_plus;
  logic [NPORT-1:0] s_minus;
  logic             s_spi;
  logic             s_dat;
  logic             s_clk;
  assign {s_mode, s_fixed, s_chg, s_plus, s_minus, s_spi, s_dat, s_clk} = sync2_q;

  // Stage machine
  hsd_stage_e stage_q;
  hsd_stage_e stage_d;
  logic [7:0] load_cnt_q;
  logic       captured_q;

  always_comb begin
    stage_d = stage_q;
    unique case (stage_q)
      HSD_STANDBY:
        stage_d = s_spi ? HSD_SPI_INIT : HSD_CFG_READ;                                  // R16 R19
      HSD_SPI_INIT:
        if (spi_probe_done) begin
          stage_d = HSD_CFG_READ;                                                       // R17
        end
      HSD_CFG_READ:
        if (dflt_load_done && load_cnt_q == 8'(LOAD_CYC)) begin
          stage_d = HSD_STRAP_READ;                                                     // R20
        end
      HSD_STRAP_READ:
        if (mgmt_slave_enable && s_dat && s_clk) begin
          stage_d = HSD_SOC_CFG;                                                        // R21
        end else begin
          stage_d = HSD_OTP_CFG;                                                        // R21
        end
      HSD_SOC_CFG:
        if (mgmt_wr_valid && mgmt_wr_addr == END_CFG_REG) begin
          stage_d = HSD_OTP_CFG;                                                        // R22 R23 R24
        end
      HSD_OTP_CFG:
        stage_d = HSD_OTP_CFG;
    endcase
  end

  // Standby under reset, all state but the strap synchroniser to defaults
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stage_q <= HSD_STANDBY;                                                           // R14 R15
    end else begin
      stage_q <= stage_d;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      load_cnt_q <= '0;
    end else if (stage_q != HSD_CFG_READ) begin
      load_cnt_q <= '0;
    end else if (load_cnt_q != 8'(LOAD_CYC)) begin
      load_cnt_q <= load_cnt_q + 8'h01;
    end
  end

  // SPI probe result
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      exec_external <= 1'b0;
      exec_addr     <= SPI_EXEC_ADDR;
    end else if (stage_q == HSD_SPI_INIT && spi_probe_done) begin
      exec_external <= spi_sig_found;                                                   // R17
      exec_addr     <= SPI_EXEC_ADDR;
    end
  end

  assign spi_probe_start = (stage_q == HSD_SPI_INIT);                                   // R16 R18
  assign otp_merge_start = (stage_q == HSD_OTP_CFG);
  assign boot_stage      = stage_q;                                                     // R26

  // Strap capture once after reset release, held until next reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      captured_q         <= 1'b0;
      mgmt_slave_enable  <= 1'b0;
      charge_ind_mode    <= 1'b0;
      port_usb2_disable  <= '0;
      port_gen1_disable  <= '0;
      fixed_port_mask    <= '0;
      charge_enable_mask <= '0;
    end else if (stage_q == HSD_CFG_READ && !captured_q && dflt_load_done && load_cnt_q == 8'(LOAD_CYC)) begin
      captured_q         <= 1'b1;                                                       // R12 R20
      mgmt_slave_enable  <= (s_mode == port_speed_indicator_slave_setting);                        // R1 R6 R25
      charge_ind_mode    <= (s_mode == charge_ind_setting);                             // R3 R25
      port_usb2_disable  <= s_plus & s_minus;                                           // R7 R8
      port_gen1_disable  <= s_plus & s_minus;                                           // R9
      fixed_port_mask    <= NPORT'(hsd_level_mask(s_fixed));                            // R10
      charge_enable_mask <= NPORT'(hsd_level_mask(s_chg));                              // R11
    end
  end

  // Indicator pin drive
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      port_speed_indicator      <= '0;
      port_speed_indicator_oe_n <= '1;
      charge_indicator          <= '0;
      charge_indicator_oe_n     <= '1;
    end else if (!captured_q) begin
      port_speed_indicator_oe_n <= '1;
      charge_indicator_oe_n     <= '1;
    end else begin
      port_speed_indicator      <= port_gen1;                                           // R2
      port_speed_indicator_oe_n <= charge_ind_mode ? '1 : ~port_connected;              // R1 R2 R6
      charge_indicator          <= ~port_chg_handshake;                                 // R5
      charge_indicator_oe_n     <= charge_ind_mode ? ~charge_enable_mask : '1;          // R3 R4
    end
  end

  // GPIO: output drives level, input applies pull
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      gpio_o     <= '0;
      gpio_oe_n  <= '1;
      gpio_pu_en <= '0;
      gpio_pd_en <= '0;
    end else begin
      gpio_o     <= gpio_out_level;                                                     // R13
      gpio_oe_n  <= ~gpio_out_mode;                                                     // R13
      gpio_pu_en <= ~gpio_out_mode & gpio_pull_up;                                      // R13
      gpio_pd_en <= ~gpio_out_mode & ~gpio_pull_up;                                     // R13
    end
  end

  // Checks
  sequence soc_end_write;
    stage_q == HSD_SOC_CFG && mgmt_wr_valid && mgmt_wr_addr == END_CFG_REG;
  endsequence

  a_soc_exit_only: assert property (@(posedge clk) disable iff (!reset_n)  // R23
    (stage_q == HSD_SOC_CFG && !(mgmt_wr_valid && mgmt_wr_addr == END_CFG_REG)) |=> stage_q == HSD_SOC_CFG)
    else $error("soc stage left without end write");

  a_soc_to_otp: assert property (@(posedge clk) disable iff (!reset_n)  // R24
    soc_end_write |=> stage_q == HSD_OTP_CFG)
    else $error("end write did not reach otp stage");

  a_strap_soc_entry: assert property (@(posedge clk) disable iff (!reset_n)  // R21
    (stage_q == HSD_STRAP_READ) |=> (stage_q == HSD_SOC_CFG) == $past(mgmt_slave_enable && s_dat && s_clk))
    else $error("strap read branch wrong");

  a_spi_skip: assert property (@(posedge clk) disable iff (!reset_n)  // R19
    (stage_q == HSD_STANDBY && !s_spi) |=> stage_q == HSD_CFG_READ)
    else $error("spi probe not skipped");

  a_port_disable: assert property (@(posedge clk) disable iff (!reset_n)  // R8
    $rose(captured_q) |-> port_usb2_disable == $past(s_plus & s_minus))
    else $error("port disable decode wrong");

  a_gen1_follow: assert property (@(posedge clk) disable iff (!reset_n)  // R9
    port_gen1_disable == port_usb2_disable)
    else $error("gen1 path not disabled with usb2");

  a_straps_held: assert property (@(posedge clk) disable iff (!reset_n)  // R12
    captured_q |=> $stable(fixed_port_mask) && $stable(charge_enable_mask) && $stable(mgmt_slave_enable))
    else $error("strap values changed after capture");

  a_charge_float: assert property (@(posedge clk) disable iff (!reset_n)  // R4
    (captured_q && charge_ind_mode) |=> charge_indicator_oe_n == ~$past(charge_enable_mask))
    else $error("charge indicator enable wrong");

  a_speed_float: assert property (@(posedge clk) disable iff (!reset_n)  // R2
    (captured_q && !charge_ind_mode) |=> port_speed_indicator_oe_n == ~$past(port_connected)
      && port_speed_indicator == $past(port_gen1))
    else $error("speed indicator drive wrong");

  a_slave_mode: assert property (@(posedge clk) disable iff (!reset_n)  // R1
    $rose(captured_q) |-> mgmt_slave_enable == ($past(s_mode) == port_speed_indicator_slave_setting))
    else $error("slave enable decode wrong");

  sequence standby_spi;
    stage_q == HSD_STANDBY && s_spi;
  endsequence

  a_probe_entry: assert property (@(posedge clk) disable iff (!reset_n)  // R16
    standby_spi |=> stage_q == HSD_SPI_INIT && spi_probe_start)
    else $error("spi strap did not start probe");

  a_float_precapture: assert property (@(posedge clk) disable iff (!reset_n)  // R15
    !captured_q |=> &port_speed_indicator_oe_n && &charge_indicator_oe_n)
    else $error("indicator driven before strap capture");

  a_charge_level: assert property (@(posedge clk) disable iff (!reset_n)  // R5
    (captured_q && charge_ind_mode) |=> charge_indicator == ~$past(port_chg_handshake))
    else $error("charge indicator level wrong");

  a_load_wait: assert property (@(posedge clk) disable iff (!reset_n)  // R20
    (stage_q == HSD_CFG_READ && !(dflt_load_done && load_cnt_q == 8'(LOAD_CYC))) |=> stage_q == HSD_CFG_READ)
    else $error("default load stage left early");

  a_otp_hold: assert property (@(posedge clk) disable iff (!reset_n)  // R24
    stage_q == HSD_OTP_CFG |=> stage_q == HSD_OTP_CFG)
    else $error("otp stage left");

endmodule : hsd_boot_sequencer

`default_nettype wire

// ---- tb/hsd_far_side_model.sv ----
// Far-side model: SPI ROM probe answer and SoC writer on the management lines
`timescale 1ns/1ps
`default_nettype none

module hsd_far_side_model (
  // Clock, reset and behaviour selection
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       sig_present,
  input  wire logic [1:0] lines_pulled,
  input  wire logic [3:0] probe_delay,
  // Device side
  input  wire logic       spi_probe_start,
  output logic            spi_probe_done,
  output logic            spi_sig_found,
  output logic            mgmt_serial_data_pin,
  output logic            mgmt_serial_clock_pin,
  output logic            mgmt_wr_valid,
  output logic [7:0]      mgmt_wr_addr
);
  logic [3:0] wait_q;
  logic       in_frame;
  logic       sclk_v;
  logic       sdat_v;

  initial begin
    in_frame      = 1'b0;
    sclk_v        = 1'b0;
    sdat_v        = 1'b0;
    mgmt_wr_valid = 1'b0;
    mgmt_wr_addr  = 8'h5a;
  end

  // One-cycle done after a chosen probe delay
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wait_q         <= 4'h0;
      spi_probe_done <= 1'b0;
    end else begin
      spi_probe_done <= spi_probe_start && !spi_probe_done && wait_q == probe_delay;
      wait_q         <= (spi_probe_start && !spi_probe_done) ? wait_q + 4'h1 : 4'h0;
    end
  end

  // Found flag only meaningful with done
  assign spi_sig_found         = spi_probe_done ? sig_present : !sig_present;
  // Idle lines sit at their pull level
  assign mgmt_serial_data_pin  = in_frame ? sdat_v : lines_pulled[1];
  assign mgmt_serial_clock_pin = in_frame ? sclk_v : lines_pulled[0];

  // Serial frame, then the decoded write for one cycle
  task automatic write_reg(input logic [7:0] addr);
    #3;
    in_frame = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      sclk_v = 1'b0;
      sdat_v = addr[i];
      #62.5;
      sclk_v = 1'b1;
      #62.5;
    end
    in_frame = 1'b0;
    @(posedge clk);
    mgmt_wr_valid <= 1'b1;
    mgmt_wr_addr  <= addr;
    @(posedge clk);
    mgmt_wr_valid <= 1'b0;
    mgmt_wr_addr  <= ~addr;
  endtask : write_reg

endmodule : hsd_far_side_model

`default_nettype wire

// ---- tb/hsd_boot_sequencer_tb.sv ----
// Self-checking bench for the strap decode and boot sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin errors++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, ex, got); end end

module hsd_boot_sequencer_tb
  import hsd_pkg::*;
;
  logic        clk, reset_n, spi_mode_strap, dflt_load_done, sig_present, spi_probe_start, spi_probe_done;
  logic        spi_sig_found, mgmt_serial_data_pin, mgmt_serial_clock_pin, mgmt_wr_valid, exec_external;
  logic        mgmt_slave_enable, charge_ind_mode, otp_merge_start;
  logic [1:0]  lines_pulled;
  logic [3:0]  probe_delay;
  logic [2:0]  mode_strap_level, fixed_port_count_strap, charging_port_count_strap, boot_stage;
  logic [6:0]  plus_line_disable_strap, minus_line_disable_strap, port_connected, port_gen1, port_chg_handshake;
  logic [6:0]  port_usb2_disable, port_gen1_disable, fixed_port_mask, charge_enable_mask;
  logic [6:0]  port_speed_indicator, port_speed_indicator_oe_n, charge_indicator, charge_indicator_oe_n;
  logic [7:0]  gpio_out_mode, gpio_out_level, gpio_pull_up, gpio_o, gpio_oe_n, gpio_pu_en, gpio_pd_en, mgmt_wr_addr;
  logic [15:0] exec_addr;
  int          errors, checked;
  logic [6:0]  tbl [6] = '{7'h00, 7'h01, 7'h03, 7'h07, 7'h0f, 7'h7f};

  hsd_boot_sequencer #(.LOAD_CYC(10)) hsd_boot_sequencer_inst (.clk, .reset_n, .mode_strap_level,
    .fixed_port_count_strap, .charging_port_count_strap, .plus_line_disable_strap, .minus_line_disable_strap,
    .spi_mode_strap, .mgmt_serial_data_pin, .mgmt_serial_clock_pin, .spi_probe_done, .spi_sig_found,
    .dflt_load_done, .mgmt_wr_valid, .mgmt_wr_addr, .port_connected, .port_gen1, .port_chg_handshake,
    .gpio_out_mode, .gpio_out_level, .gpio_pull_up, .boot_stage, .spi_probe_start, .exec_external, .exec_addr,
    .mgmt_slave_enable, .charge_ind_mode, .port_usb2_disable, .port_gen1_disable, .fixed_port_mask,
    .charge_enable_mask, .otp_merge_start, .port_speed_indicator, .port_speed_indicator_oe_n, .charge_indicator,
    .charge_indicator_oe_n, .gpio_o, .gpio_oe_n, .gpio_pu_en, .gpio_pd_en);
  hsd_far_side_model hsd_far_side_model_inst (.clk, .reset_n, .sig_present, .lines_pulled, .probe_delay,
    .spi_probe_start, .spi_probe_done, .spi_sig_found, .mgmt_serial_data_pin, .mgmt_serial_clock_pin,
    .mgmt_wr_valid, .mgmt_wr_addr);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic final_report();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report

  task automatic wait_stage(input logic [2:0] s);
    for (int n = 0; n < 60 && boot_stage !== s; n++) @(negedge clk);
    `CHK("boot_stage", s, boot_stage)
  endtask : wait_stage

  // Reset held 5 cycles with straps set, ends after first edge past release
  task automatic boot(input logic [2:0] md, fx, cg, input logic sp);
    @(posedge clk);
    reset_n                   <= 1'b0;
    mode_strap_level          <= md;
    fixed_port_count_strap    <= fx;
    charging_port_count_strap <= cg;
    spi_mode_strap            <= sp;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    @(negedge clk);
  endtask : boot

  task automatic t_slave();
    lines_pulled = 2'b11;
    sig_present  = 1'b1;
    probe_delay  = 4'h4;
    boot(3'h1, 3'h0, 3'h0, 1'b1);
    `CHK("stage", HSD_SPI_INIT, boot_stage)
    `CHK("probe", 1'b1, spi_probe_start)
    wait_stage(HSD_CFG_READ);
    `CHK("ext", 1'b1, exec_external)
    `CHK("addr", 16'h0000, exec_addr)
    wait_stage(HSD_SOC_CFG);
    `CHK("slave", 1'b1, mgmt_slave_enable)
    hsd_far_side_model_inst.write_reg(8'h10);
    repeat (40) @(negedge clk);
    `CHK("stage", HSD_SOC_CFG, boot_stage)
    hsd_far_side_model_inst.write_reg(END_CFG_REG);
    wait_stage(HSD_OTP_CFG);
    `CHK("otp", 1'b1, otp_merge_start)
  endtask : t_slave

  task automatic t_levels();
    for (int i = 0; i < 6; i++) begin
      boot(i[2:0], i[2:0], 3'(5 - i), 1'b0);
      `CHK("stage", HSD_CFG_READ, boot_stage)
      wait_stage(i == 1 ? HSD_SOC_CFG : HSD_OTP_CFG);
      `CHK("fixed", tbl[i], fixed_port_mask)
      `CHK("chg", tbl[5 - i], charge_enable_mask)
      `CHK("slave", i == 1, mgmt_slave_enable)
      `CHK("cmode", i == 4, charge_ind_mode)
      `CHK("ext", 1'b0, exec_external)
    end
  endtask : t_levels

  task automatic t_ports();
    lines_pulled = 2'b01;
    @(posedge clk);
    plus_line_disable_strap  <= 7'h55;
    minus_line_disable_strap <= 7'h33;
    dflt_load_done           <= 1'b0;
    boot(3'h1, 3'h0, 3'h0, 1'b0);
    repeat (15) @(negedge clk);
    `CHK("stage", HSD_CFG_READ, boot_stage)
    `CHK("usb2", 7'h00, port_usb2_disable)
    @(posedge clk);
    dflt_load_done <= 1'b1;
    wait_stage(HSD_OTP_CFG);
    `CHK("usb2", 7'h11, port_usb2_disable)
    `CHK("gen1", 7'h11, port_gen1_disable)
    @(posedge clk);
    plus_line_disable_strap  <= 7'h7f;
    minus_line_disable_strap <= 7'h7f;
    fixed_port_count_strap   <= 3'h5;
    repeat (5) @(negedge clk);
    `CHK("usb2", 7'h11, port_usb2_disable)
    `CHK("fixed", 7'h00, fixed_port_mask)
  endtask : t_ports

  task automatic t_ind();
    boot(3'h0, 3'h0, 3'h0, 1'b0);
    wait_stage(HSD_OTP_CFG);
    @(posedge clk);
    port_connected     <= 7'h0b;
    port_gen1          <= 7'h0a;
    port_chg_handshake <= 7'h05;
    repeat (2) @(negedge clk);
    `CHK("spd_oe_n", 7'h74, port_speed_indicator_oe_n)
    `CHK("spd", 7'h0a, port_speed_indicator & 7'h0b)
    `CHK("chg_oe_n", 7'h7f, charge_indicator_oe_n)
    boot(3'h4, 3'h0, 3'h2, 1'b0);
    wait_stage(HSD_OTP_CFG);
    repeat (2) @(negedge clk);
    `CHK("spd_oe_n", 7'h7f, port_speed_indicator_oe_n)
    `CHK("chg_oe_n", 7'h7c, charge_indicator_oe_n)
    `CHK("chg", 7'h02, charge_indicator & 7'h03)
  endtask : t_ind

  task automatic t_gpio_standby();
    @(posedge clk);
    gpio_out_mode  <= 8'h0f;
    gpio_out_level <= 8'h05;
    gpio_pull_up   <= 8'h30;
    repeat (2) @(negedge clk);
    `CHK("oe_n", 8'hf0, gpio_oe_n)
    `CHK("out", 8'h05, gpio_o & 8'h0f)
    `CHK("pu", 8'h30, gpio_pu_en)
    `CHK("pd", 8'hc0, gpio_pd_en)
    @(posedge clk);
    reset_n <= 1'b0;
    @(negedge clk);
    `CHK("stage", HSD_STANDBY, boot_stage)
    `CHK("chg_oe_n", 7'h7f, charge_indicator_oe_n)
    `CHK("gpio_oe_n", 8'hff, gpio_oe_n)
    `CHK("fixed", 7'h00, fixed_port_mask)
    `CHK("chg_en", 7'h00, charge_enable_mask)
  endtask : t_gpio_standby

  initial begin
    {reset_n, spi_mode_strap, sig_present, lines_pulled, probe_delay} = '0;
    {mode_strap_level, fixed_port_count_strap, charging_port_count_strap} = '0;
    {plus_line_disable_strap, minus_line_disable_strap, port_connected, port_gen1, port_chg_handshake} = '0;
    {gpio_out_mode, gpio_out_level, gpio_pull_up} = '0;
    dflt_load_done = 1'b1;
    errors         = 0;
    checked        = 0;
    t_slave();
    t_levels();
    t_ports();
    t_ind();
    t_gpio_standby();
    final_report();
  end

  // Hang guard, well beyond the expected run
  initial begin
    #50000;
    errors++;
    final_report();
  end

endmodule : hsd_boot_sequencer_tb

`default_nettype wire
